// >>> verilog/sensorless_consts.vh
// Constants for the sensorless start-up, estimator and current sampling block.
`ifndef SENSORLESS_CONSTS_VH
`define SENSORLESS_CONSTS_VH

`define A_CTRL 4'h0
`define A_PARK_ANG 4'h1
`define A_PARK_LEN 4'h2
`define A_PARK_CUR 4'h3
`define A_START_CUR 4'h4
`define A_RAMP 4'h5
`define A_THRESH 4'h6
`define A_GAIN 4'h7
`define A_MODEL 4'h8
`define A_CUTOFF 4'h9
`define A_SAMP_DLY 4'ha
`define A_PWM_HALF 4'hb
`define A_STATUS 4'hc
`define A_ANGLE 4'hd
`define A_FREQ 4'he
`define A_VEL 4'hf

`define CTRL_RUN 0
`define CTRL_PARK2 1
`define CTRL_POLE_LO 4
`define CTRL_POLE_HI 6

`define RST_CTRL 16'h0000
`define RST_PARK_LEN 16'h0400
`define RST_PARK_CUR 16'h0400
`define RST_START_CUR 16'h0400
`define RST_RAMP 16'h0001
`define RST_THRESH 16'h0200
`define RST_GAIN 16'h1020
`define RST_MODEL 16'h1010
`define RST_CUTOFF 16'h000a
`define RST_SAMP_DLY 16'h0808
`define RST_PWM_HALF 16'h0a00

`define PARK2_SHIFT 16'h2aab
`define QUARTER_TURN 16'h4000
`define VINT_SHIFT 4
`define SQRT3_HALF 16'h6eda
`define INV_SQRT3 16'h49e7
`define SIN_MAX 16'h7fff

`endif

// >>> verilog/sensorless_start.v
// Sensorless estimator, start-up sequencer, modulator and shunt current rebuild.
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sensorless_consts.vh"

module sensorless_start (
    input wire ref_clk,
    input wire rst_n,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [15:0] cmp_u,
    input wire [15:0] cmp_v,
    input wire [15:0] cmp_w,
    input wire signed [15:0] v_alpha,
    input wire signed [15:0] v_beta,
    input wire signed [15:0] vel_cmd,
    input wire adc_done,
    input wire [15:0] adc_data,
    output reg adc_start,
    output reg [2:0] pwm_high,
    output reg signed [15:0] i_u,
    output reg signed [15:0] i_v,
    output reg signed [15:0] i_w,
    output reg signed [15:0] ctrl_angle,
    output reg signed [15:0] ref_u,
    output reg signed [15:0] ref_v,
    output reg signed [15:0] ref_w,
    output reg loop_enable,
    output reg signed [15:0] vel_target,
    output reg signed [15:0] vel_est
);

    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_PARK1 = 5'h02;
    localparam [4:0] S_PARK2 = 5'h04;
    localparam [4:0] S_START = 5'h08;
    localparam [4:0] S_RUN = 5'h10;

    // Parabolic sine approximation over a 16-bit full turn.
    function signed [15:0] sin_apx;
        input [15:0] ang;
        reg [15:0] u;
        reg [31:0] p;
        reg [15:0] y;
        begin
            u = {1'b0, ang[14:0]};
            p = u * (16'h8000 - u);
            y = p[28:13];
            if (y[15]) begin
                y = `SIN_MAX;
            end
            sin_apx = ang[15] ? -y : y;
        end
    endfunction

    reg [15:0] ctrl_r, park_ang_r, park_len_r, park_cur_r, start_cur_r;
    reg [15:0] ramp_r, thresh_r, gain_r, model_r, cutoff_r, dly_r, half_r;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r <= `RST_CTRL;
            park_ang_r <= 16'h0000;
            park_len_r <= `RST_PARK_LEN;
            park_cur_r <= `RST_PARK_CUR;
            start_cur_r <= `RST_START_CUR;
            ramp_r <= `RST_RAMP;
            thresh_r <= `RST_THRESH;
            gain_r <= `RST_GAIN;
            model_r <= `RST_MODEL;
            cutoff_r <= `RST_CUTOFF;
            dly_r <= `RST_SAMP_DLY;
            half_r <= `RST_PWM_HALF;
        end else if (reg_wr) begin
            case (reg_addr)
                `A_CTRL: ctrl_r <= reg_wdata;
                `A_PARK_ANG: park_ang_r <= reg_wdata;
                `A_PARK_LEN: park_len_r <= reg_wdata;
                `A_PARK_CUR: park_cur_r <= reg_wdata;
                `A_START_CUR: start_cur_r <= reg_wdata;
                `A_RAMP: ramp_r <= reg_wdata;
                `A_THRESH: thresh_r <= reg_wdata;
                `A_GAIN: gain_r <= reg_wdata;
                `A_MODEL: model_r <= reg_wdata;
                `A_CUTOFF: cutoff_r <= reg_wdata;
                `A_SAMP_DLY: dly_r <= reg_wdata;
                `A_PWM_HALF: half_r <= reg_wdata;
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // Converter handshake arrives from outside the clock domain.
    reg done_m_r, done_s_r, done_d_r;
    reg [15:0] data_m_r, data_s_r;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            done_m_r <= 1'b0;
            done_s_r <= 1'b0;
            done_d_r <= 1'b0;
            data_m_r <= 16'h0000;
            data_s_r <= 16'h0000;
        end else begin
            done_m_r <= adc_done;
            done_s_r <= done_m_r;
            done_d_r <= done_s_r;
            data_m_r <= adc_data;
            data_s_r <= data_m_r;
        end
    end

    wire done_rise = done_s_r & ~done_d_r;
    reg [15:0] cnt_r;
    reg down_r;
    reg [15:0] cu_r, cv_r, cw_r;
    wire tick = down_r && (cnt_r == 16'h0001 || cnt_r == 16'h0000);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_r <= 16'h0000;
            down_r <= 1'b0;
            cu_r <= 16'hffff;
            cv_r <= 16'hffff;
            cw_r <= 16'hffff;
        end else if (tick) begin
            cnt_r <= 16'h0000;
            down_r <= 1'b0;
            cu_r <= cmp_u;
            cv_r <= cmp_v;
            cw_r <= cmp_w;
        end else if (!down_r) begin
            cnt_r <= cnt_r + 16'h0001;
            down_r <= (cnt_r + 16'h0001 >= half_r);
        end else begin
            cnt_r <= cnt_r - 16'h0001;
        end
    end
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            pwm_high <= 3'b000;
        end else begin
            pwm_high <= {cnt_r >= cw_r, cnt_r >= cv_r, cnt_r >= cu_r};
        end
    end

    // Sort the phases: the lowest compare switches first, the highest last.
    reg [1:0] lo_idx, hi_idx;
    reg [15:0] lo_cmp, mid_cmp;

    always @* begin
        lo_idx = 2'd0;
        hi_idx = 2'd0;
        lo_cmp = cu_r;
        mid_cmp = cu_r;
        if (cu_r <= cv_r && cu_r <= cw_r) begin
            hi_idx = (cv_r > cw_r) ? 2'd1 : 2'd2;
            mid_cmp = (cv_r > cw_r) ? cw_r : cv_r;
        end else if (cv_r <= cw_r) begin
            lo_idx = 2'd1;
            lo_cmp = cv_r;
            hi_idx = (cu_r > cw_r) ? 2'd0 : 2'd2;
            mid_cmp = (cu_r > cw_r) ? cw_r : cu_r;
        end else begin
            lo_idx = 2'd2;
            lo_cmp = cw_r;
            hi_idx = (cu_r > cv_r) ? 2'd0 : 2'd1;
            mid_cmp = (cu_r > cv_r) ? cv_r : cu_r;
        end
    end

    wire [16:0] s1_at = {1'b0, lo_cmp} + {9'h000, dly_r[7:0]};
    wire [16:0] s2_at = {1'b0, mid_cmp} + {9'h000, dly_r[15:8]};
    wire s1_hit = !down_r && {1'b0, cnt_r} == s1_at;
    wire s2_hit = !down_r && {1'b0, cnt_r} == s2_at;

    // First active state: one phase high, shunt shows its current.
    // Second active state: one phase low, shunt shows its negated current.
    reg second_r;
    reg [1:0] s_idx_r;
    reg signed [15:0] ph0_r, ph1_r, ph2_r;
    wire signed [15:0] sample = second_r ? -data_s_r : data_s_r;
    wire signed [15:0] lo_val = lo_idx[1] ? ph2_r : (lo_idx[0] ? ph1_r : ph0_r);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            adc_start <= 1'b0;
            second_r <= 1'b0;
            s_idx_r <= 2'd0;
            ph0_r <= 16'h0000;
            ph1_r <= 16'h0000;
            ph2_r <= 16'h0000;
        end else begin
            adc_start <= s1_hit | s2_hit;
            if (s1_hit) begin
                second_r <= 1'b0;
                s_idx_r <= lo_idx;
            end else if (s2_hit) begin
                second_r <= 1'b1;
                s_idx_r <= hi_idx;
            end
            if (done_rise) begin
                case (s_idx_r)
                    2'd0: ph0_r <= sample;
                    2'd1: ph1_r <= sample;
                    default: ph2_r <= sample;
                endcase
                if (second_r) begin
                    case (3'd3 - {1'b0, s_idx_r} - {1'b0, lo_idx})
                        3'd0: ph0_r <= -(lo_val + sample);
                        3'd1: ph1_r <= -(lo_val + sample);
                        default: ph2_r <= -(lo_val + sample);
                    endcase
                end
            end
        end
    end
    wire signed [15:0] i_al = ph0_r;
    wire signed [31:0] ib_p = (ph0_r + 2 * ph1_r) * $signed(`INV_SQRT3);
    wire signed [15:0] i_be = ib_p[30:15];
    reg signed [15:0] psi_a_r, psi_b_r;
    wire signed [8:0] rs = {1'b0, model_r[7:0]};
    wire signed [8:0] ls = {1'b0, model_r[15:8]};
    wire signed [24:0] ra = i_al * rs;
    wire signed [24:0] rb = i_be * rs;
    wire signed [24:0] la = i_al * ls;
    wire signed [24:0] lb = i_be * ls;
    wire signed [15:0] ea = v_alpha - ra[23:8];
    wire signed [15:0] eb = v_beta - rb[23:8];
    wire signed [15:0] fx = la[23:8] - psi_a_r;
    wire signed [15:0] fy = lb[23:8] - psi_b_r;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            psi_a_r <= 16'h0000;
            psi_b_r <= 16'h0000;
        end else if (tick) begin
            psi_a_r <= psi_a_r + (ea >>> `VINT_SHIFT) - (psi_a_r >>> cutoff_r[3:0]);
            psi_b_r <= psi_b_r + (eb >>> `VINT_SHIFT) - (psi_b_r >>> cutoff_r[3:0]);
        end
    end
    reg signed [15:0] ang_r, frq_r, integ_r;
    wire signed [15:0] sn = sin_apx(ang_r);
    wire signed [15:0] cs = sin_apx(ang_r + `QUARTER_TURN);
    wire signed [31:0] ep = fy * cs - fx * sn;
    wire signed [15:0] err = ep[30:15];
    wire signed [8:0] kp = {1'b0, gain_r[7:0]};
    wire signed [8:0] ki = {1'b0, gain_r[15:8]};
    wire signed [24:0] pterm = err * kp;
    wire signed [24:0] iterm = err * ki;
    wire signed [15:0] integ_nxt = integ_r + iterm[23:8];
    wire signed [15:0] frq_cl = integ_nxt + pterm[23:8];
    reg [4:0] st_r;
    reg [15:0] park_cnt_r;
    reg run_d_r;
    wire run_cmd = ctrl_r[`CTRL_RUN];
    wire at_thresh = frq_r >= $signed(thresh_r);
    wire park_done = park_cnt_r >= park_len_r;
    wire [15:0] park2_ang = park_ang_r + `PARK2_SHIFT;

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            park_cnt_r <= 16'h0000;
            run_d_r <= 1'b0;
            ang_r <= 16'h0000;
            frq_r <= 16'h0000;
            integ_r <= 16'h0000;
        end else begin
            run_d_r <= run_cmd;
            if (!run_cmd) begin
                st_r <= S_IDLE;
                park_cnt_r <= 16'h0000;
                ang_r <= 16'h0000;
                frq_r <= 16'h0000;
                integ_r <= 16'h0000;
            end else begin
                case (st_r)
                    S_IDLE: begin
                        if (!run_d_r) begin
                            st_r <= S_PARK1;
                            park_cnt_r <= 16'h0000;
                            ang_r <= park_ang_r;
                        end
                    end
                    S_PARK1: begin
                        ang_r <= park_ang_r;
                        frq_r <= 16'h0000;
                        if (tick) begin
                            park_cnt_r <= park_cnt_r + 16'h0001;
                        end
                        if (park_done) begin
                            park_cnt_r <= 16'h0000;
                            st_r <= ctrl_r[`CTRL_PARK2] ? S_PARK2 : S_START;
                            ang_r <= ctrl_r[`CTRL_PARK2] ? park2_ang : park_ang_r;
                        end
                    end
                    S_PARK2: begin
                        ang_r <= park2_ang;
                        frq_r <= 16'h0000;
                        if (tick) begin
                            park_cnt_r <= park_cnt_r + 16'h0001;
                        end
                        if (park_done) begin
                            st_r <= S_START;
                        end
                    end
                    S_START: begin
                        if (at_thresh) begin
                            st_r <= S_RUN;
                            integ_r <= frq_r;
                        end else if (tick) begin
                            frq_r <= frq_r + ramp_r;
                            ang_r <= ang_r + frq_r;
                        end
                    end
                    S_RUN: begin
                        if (tick) begin
                            integ_r <= integ_nxt;
                            frq_r <= frq_cl;
                            ang_r <= ang_r + frq_cl;
                        end
                    end
                    default: st_r <= S_IDLE;
                endcase
            end
        end
    end

    // Current reference at the park or start angle, split over windings.
    wire park_st = st_r == S_PARK1 || st_r == S_PARK2;
    wire [15:0] mag = park_st ? park_cur_r : (st_r == S_START ? start_cur_r : 16'h0000);
    wire signed [31:0] ra_p = $signed(mag) * cs;
    wire signed [31:0] rb_p = $signed(mag) * sn;
    wire signed [15:0] r_al = ra_p[30:15];
    wire signed [15:0] r_be = rb_p[30:15];
    wire signed [31:0] rv_p = r_be * $signed(`SQRT3_HALF);
    wire signed [15:0] r_v = rv_p[30:15] - (r_al >>> 1);
    wire [2:0] pp = ctrl_r[`CTRL_POLE_HI:`CTRL_POLE_LO];
    wire signed [31:0] vel_p = frq_r * $signed({1'b0, 15'h7fff / ({12'h000, pp} + 15'h0001)});

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            i_u <= 16'h0000;
            i_v <= 16'h0000;
            i_w <= 16'h0000;
            ctrl_angle <= 16'h0000;
            ref_u <= 16'h0000;
            ref_v <= 16'h0000;
            ref_w <= 16'h0000;
            loop_enable <= 1'b0;
            vel_target <= 16'h0000;
            vel_est <= 16'h0000;
        end else begin
            i_u <= ph0_r;
            i_v <= ph1_r;
            i_w <= ph2_r;
            ctrl_angle <= ang_r;
            ref_u <= r_al;
            ref_v <= r_v;
            ref_w <= -(r_al + r_v);
            loop_enable <= st_r == S_RUN;
            vel_target <= (st_r == S_RUN) ? vel_cmd : 16'h0000;
            vel_est <= vel_p[30:15];
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `A_CTRL: reg_rdata <= ctrl_r;
                `A_PARK_ANG: reg_rdata <= park_ang_r;
                `A_PARK_LEN: reg_rdata <= park_len_r;
                `A_PARK_CUR: reg_rdata <= park_cur_r;
                `A_START_CUR: reg_rdata <= start_cur_r;
                `A_RAMP: reg_rdata <= ramp_r;
                `A_THRESH: reg_rdata <= thresh_r;
                `A_GAIN: reg_rdata <= gain_r;
                `A_MODEL: reg_rdata <= model_r;
                `A_CUTOFF: reg_rdata <= cutoff_r;
                `A_SAMP_DLY: reg_rdata <= dly_r;
                `A_PWM_HALF: reg_rdata <= half_r;
                `A_STATUS: reg_rdata <= {11'h000, st_r};
                `A_ANGLE: reg_rdata <= ang_r;
                `A_FREQ: reg_rdata <= frq_r;
                default: reg_rdata <= vel_est;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // sensorless_start
`default_nettype wire

// >>> test/sensorless_start_asserts.sv
// Concurrent checks on the ports of the sensorless start-up block.
`timescale 1ns/10ps
`default_nettype none
module sensorless_start_asserts (
    input wire ref_clk,
    input wire rst_n,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire signed [15:0] vel_cmd,
    input wire adc_start,
    input wire [2:0] pwm_high,
    input wire signed [15:0] ref_u,
    input wire signed [15:0] ref_v,
    input wire signed [15:0] ref_w,
    input wire loop_enable,
    input wire signed [15:0] vel_target
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_start_pulse: assert property (adc_start |=> !adc_start [*8])
        else $error("adc_start not a lone pulse");
    chk_sample_active: assert property (adc_start |-> $countones(pwm_high) inside {1, 2})
        else $error("sample outside an active state");
    chk_pwm_step: assert property ($countones(pwm_high ^ $past(pwm_high)) <= 1)
        else $error("pwm_high skipped a state");
    chk_run_refs: assert property (loop_enable |-> ref_u == 0 && ref_v == 0 && ref_w == 0)
        else $error("current references driven in closed loop");
    chk_target_follow: assert property (loop_enable && $past(loop_enable)
        |-> vel_target == $past(vel_cmd))
        else $error("vel_target does not follow vel_cmd");
    chk_target_idle: assert property (!loop_enable && !$past(loop_enable) |-> vel_target == 0)
        else $error("vel_target set outside closed loop");
    chk_stop_idle: assert property (reg_wr && reg_addr == 4'h0 && !reg_wdata[0]
        |-> ##[1:4] (!loop_enable && ref_u == 0 && ref_v == 0 && ref_w == 0))
        else $error("stop did not return to idle");
    chk_status_hot: assert property (reg_rd && reg_addr == 4'hc
        |=> reg_rdata[15:5] == 11'h000 && $onehot(reg_rdata[4:0]))
        else $error("status not one-hot");
    chk_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
endmodule // sensorless_start_asserts

bind sensorless_start sensorless_start_asserts i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .vel_cmd(vel_cmd), .adc_start(adc_start), .pwm_high(pwm_high),
    .ref_u(ref_u), .ref_v(ref_v), .ref_w(ref_w), .loop_enable(loop_enable),
    .vel_target(vel_target));
`default_nettype wire

// >>> test/shunt_adc_model.sv
// Behavioural dc-link shunt and converter on the far side of the block.
`timescale 1ns/10ps
`default_nettype none
module shunt_adc_model #(
    parameter logic [15:0] I_U = 16'h0000,
    parameter logic [15:0] I_V = 16'h0000,
    parameter logic [15:0] I_W = 16'h0000
) (
    input wire logic ref_clk,
    input wire logic adc_start,
    input wire logic [2:0] pwm_high,
    output logic adc_done,
    output logic [15:0] adc_data
);
    logic [15:0] link_r;
    logic [3:0] cnt_r;
    initial begin
        adc_done = 1'b0;
        adc_data = 16'h5a5a;
        link_r = 16'h0000;
        cnt_r = 4'h0;
    end
    // The link carries the sum of the windings on the high rail.
    always @(posedge ref_clk) begin
        if (adc_start) begin
            link_r <= (pwm_high[0] ? I_U : 16'h0000) + (pwm_high[1] ? I_V : 16'h0000)
                + (pwm_high[2] ? I_W : 16'h0000);
            cnt_r <= 4'h1;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r + 4'h1;
        end
        if (cnt_r == 4'h3) begin
            adc_data <= link_r;
            adc_done <= 1'b1;
        end else if (cnt_r == 4'h7) begin
            adc_done <= 1'b0;
            adc_data <= ~link_r;
            cnt_r <= 4'h0;
        end
    end
endmodule // shunt_adc_model
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the sensorless start-up block.
`timescale 1ns/10ps
`default_nettype none
`include "sensorless_consts.vh"
module tb;
    localparam logic [15:0] CU = 16'h0123;
    localparam logic [15:0] CV = 16'h0045;
    localparam logic [15:0] CW = 16'hfe98;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] cmp_u = 16'h0010;
    logic [15:0] cmp_v = 16'h0020;
    logic [15:0] cmp_w = 16'h0030;
    logic signed [15:0] v_alpha = 16'sh0100;
    logic signed [15:0] v_beta = 16'sh0080;
    logic signed [15:0] vel_cmd = 16'sh0123;
    wire adc_done;
    wire [15:0] adc_data;
    wire adc_start;
    wire [2:0] pwm_high;
    wire signed [15:0] i_u, i_v, i_w, ctrl_angle, ref_u, ref_v, ref_w, vel_target, vel_est;
    wire [15:0] reg_rdata;
    wire loop_enable;
    integer bad_count = 0;
    integer tests_run = 0;
    logic [15:0] rdv;

    sensorless_start i_sensorless_start (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmp_u(cmp_u), .cmp_v(cmp_v), .cmp_w(cmp_w), .v_alpha(v_alpha), .v_beta(v_beta),
        .vel_cmd(vel_cmd), .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start),
        .pwm_high(pwm_high), .i_u(i_u), .i_v(i_v), .i_w(i_w), .ctrl_angle(ctrl_angle),
        .ref_u(ref_u), .ref_v(ref_v), .ref_w(ref_w), .loop_enable(loop_enable),
        .vel_target(vel_target), .vel_est(vel_est));
    shunt_adc_model #(.I_U(CU), .I_V(CV), .I_W(CW)) i_shunt_adc_model (.ref_clk(ref_clk),
        .adc_start(adc_start), .pwm_high(pwm_high), .adc_done(adc_done), .adc_data(adc_data));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task results;
        if (bad_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask

    task poll(input logic [4:0] exp);
        integer n;
        rdv = 16'h0000;
        for (n = 0; n < 1000 && rdv[4:0] !== exp; n = n + 1) begin
            rd(`A_STATUS);
        end
        if (rdv[4:0] !== exp) begin
            chk("status wait", {11'h000, exp}, rdv);
            results;
        end
    endtask

    task wait_pwm(input logic [2:0] v, input logic eq);
        integer n;
        for (n = 0; n < 300 && (pwm_high === v) !== eq; n = n + 1) begin
            @(posedge ref_clk);
            #1;
        end
        if ((pwm_high === v) !== eq) begin
            chk("pwm wait", {13'h0000, v}, {13'h0000, pwm_high});
            results;
        end
    endtask

    task wait_samp;
        integer n;
        n = 0;
        @(posedge ref_clk);
        #1;
        while (adc_start !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1;
            n = n + 1;
        end
        if (adc_start !== 1'b1) begin
            chk("adc_start wait", 16'h0001, 16'h0000);
            results;
        end
    endtask

    task t_regs;
        rd(`A_PARK_LEN);
        chk("park_len", `RST_PARK_LEN, rdv);
        rd(`A_THRESH);
        chk("thresh", `RST_THRESH, rdv);
        rd(`A_PWM_HALF);
        chk("pwm_half", 16'h0040, rdv);
        wr(`A_STATUS, 16'hffff);
        rd(`A_STATUS);
        chk("status", 16'h0001, rdv);
        chk("refs idle", 16'h0000, ref_u | ref_v | ref_w);
    endtask

    task t_pwm;
        logic [17:0] seq;
        integer k;
        seq = {3'b001, 3'b011, 3'b111, 3'b011, 3'b001, 3'b000};
        wait_pwm(3'b111, 1'b1);
        wait_pwm(3'b000, 1'b1);
        for (k = 0; k < 6; k = k + 1) begin
            wait_pwm(pwm_high, 1'b0);
            chk("pwm_high", {13'h0000, seq[17 - 3 * k -: 3]}, {13'h0000, pwm_high});
        end
    endtask

    task t_samp;
        integer n;
        wr(`A_SAMP_DLY, 16'h0804);
        wait_pwm(3'b000, 1'b1);
        wait_samp;
        for (n = 1; n < 40; n = n + 1) begin
            @(posedge ref_clk);
            #1;
            if (adc_start === 1'b1) break;
        end
        chk("sample gap", 16'h0014, n[15:0]);
        repeat (200) @(posedge ref_clk);
        chk("i_u", CU, i_u);
        chk("i_w", CW, i_w);
        chk("i_v", CV, i_v);
    endtask

    task t_start;
        logic [15:0] f1;
        logic [31:0] p;
        wr(`A_PARK_ANG, 16'h1000);
        wr(`A_PARK_LEN, 16'h0002);
        wr(`A_RAMP, 16'h0010);
        wr(`A_THRESH, 16'h0080);
        wr(`A_CTRL, 16'h0013);
        rd(`A_STATUS);
        chk("status park1", 16'h0002, rdv);
        chk("park angle", 16'h1000, ctrl_angle);
        chk("park refs", 16'h0001, {15'h0000, (ref_u | ref_v | ref_w) != 16'h0000});
        poll(5'b00100);
        chk("park2 angle", 16'h3aab, ctrl_angle);
        poll(5'b01000);
        wait_samp;
        rd(`A_FREQ);
        f1 = rdv;
        repeat (2) wait_samp;
        rd(`A_FREQ);
        chk("ramp step", f1 + 16'h0010, rdv);
        p = {16'h0000, rdv} * 32'h0000_3fff;
        chk("vel_est", p[30:15], vel_est);
        poll(5'b10000);
        chk("loop_enable", 16'h0001, {15'h0000, loop_enable});
        @(posedge ref_clk);
        vel_cmd <= 16'sh0200;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("vel_target", 16'h0200, vel_target);
        wr(`A_CTRL, 16'h0012);
        rd(`A_STATUS);
        chk("status stop", 16'h0001, rdv);
        rd(`A_FREQ);
        chk("freq cleared", 16'h0000, rdv);
        wr(`A_CTRL, 16'h0013);
        rd(`A_STATUS);
        chk("restart park1", 16'h0002, rdv);
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        wr(`A_PWM_HALF, 16'h0040);
        t_regs;
        t_pwm;
        t_samp;
        t_start;
        results;
    end
endmodule // tb
`default_nettype wire
